// ---- gpb_port.sv ----
// Byte-wide port with pull-ups, change-detect interrupt and alt routing.
// Assumes an APB master on clk_i and external pins on the same board;
// pin inputs, the comparator output and the shutdown input are asynchronous and synchronised here.
//
// Design decisions made here: the APB register port and the register addresses.
`default_nettype none

module gpb_port
    import gpb_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    input  wire logic [3:0]  pstrb_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic [7:0]  port_b_pins_i,
    output logic      [7:0]  port_b_pins_o,
    output logic      [7:0]  port_b_pins_oe_o,
    output logic      [7:0]  pullup_en_o,
    input  wire logic        comparator_one_out_i,
    input  wire logic        pwm_out_b_i,
    input  wire logic        pwm_out_c_i,
    input  wire logic        pwm_out_d_i,
    input  wire logic        pwm_shutdown_i,
    output logic      [3:0]  ext_irq_in_o,
    output logic             pwm_fault_in_o,
    output logic             analog_ch_ten_en_o,
    output logic             analog_ch_eight_en_o,
    output logic             timing_unit_delay_in_o,
    output logic             timing_edge_one_in_o,
    output logic             timing_edge_two_in_o,
    output logic             timer_clk_in_o,
    output logic             timer_gate_in_o,
    output logic             wake_o,
    output logic             irq_o
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [7:0]          pin_meta;
    logic [7:0]          pin_sync;
    logic [2:0]          ctl_meta;
    logic [2:0]          ctl_sync;
    logic [7:0]          direction_reg;
    logic [7:0]          output_latch_reg;
    logic [7:0]          irq_control_two;
    logic [7:0]          alt_sel;
    logic                change_irq_flag;
    logic                change_ie;
    logic [3:0]          snapshot;
    logic [1:0]          clr_block;
    logic [IRQ_BITS-1:0] irq_status;
    logic [IRQ_BITS-1:0] irq_mask;
    logic [3:0]          ext_prev;

    logic                wr_en;
    logic                rd_en;
    logic                port_access;
    logic                port_read;
    logic [3:0]          mismatch;
    logic                any_mismatch;
    logic [3:0]          ext_now;
    logic [IRQ_BITS-1:0] events;
    logic [7:0]          next_pins;
    logic [7:0]          next_oe;
    logic [31:0]         next_rdata;

    // Byte lane zero enables a write; only the low byte holds data.
    function automatic logic [7:0] merge_byte(input logic [7:0] old_v,
                                              input logic [31:0] wd,
                                              input logic [3:0] strb);
        merge_byte = strb[0] ? wd[7:0] : old_v;
    endfunction

    // Address match for an APB access phase.
    function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
        hit = (a == r);
    endfunction

    assign wr_en = psel_i & penable_i & pwrite_i;
    assign rd_en = psel_i & penable_i & ~pwrite_i;
    // Any port read or write ends the mismatch by refreshing the snapshot.
    assign port_access = psel_i & penable_i & hit(paddr_i, ADDR_PORT);
    assign port_read   = port_access;

    // ------------------------------------------------------------------
    // Two-flop synchronisers for pins and peripheral control inputs.
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pin_meta <= 8'h00;
            pin_sync <= 8'h00;
            ctl_meta <= 3'h0;
            ctl_sync <= 3'h0;
        end else begin
            pin_meta <= port_b_pins_i;
            pin_sync <= pin_meta;
            ctl_meta <= {pwm_shutdown_i, comparator_one_out_i, 1'b0};
            ctl_sync <= ctl_meta;
        end
    end

    // ------------------------------------------------------------------
    // Software registers: direction, latch, control, alt select.
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            direction_reg    <= DIR_RESET;
            output_latch_reg <= LAT_RESET;
            irq_control_two  <= CTRL2_RESET;
            alt_sel          <= ALT_RESET;
            change_ie        <= 1'b0;
            irq_mask         <= '0;
        end else if (wr_en) begin
            // Port writes land in the latch, just like latch writes.
            if (hit(paddr_i, ADDR_PORT) || hit(paddr_i, ADDR_LATCH)) begin
                output_latch_reg <= merge_byte(output_latch_reg, pwdata_i, pstrb_i);
            end
            if (hit(paddr_i, ADDR_DIR)) begin
                direction_reg <= merge_byte(direction_reg, pwdata_i, pstrb_i);
            end
            if (hit(paddr_i, ADDR_CTRL2)) begin
                irq_control_two <= merge_byte(irq_control_two, pwdata_i, pstrb_i);
            end
            if (hit(paddr_i, ADDR_ALT)) begin
                alt_sel <= merge_byte(alt_sel, pwdata_i, pstrb_i);
            end
            if (hit(paddr_i, ADDR_CTRL) && pstrb_i[0]) begin
                change_ie <= pwdata_i[CHANGE_FLAG_BIT + 1];
            end
            if (hit(paddr_i, ADDR_IRQ_MSK) && pstrb_i[0]) begin
                irq_mask <= pwdata_i[IRQ_BITS-1:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Change detection on the upper nibble.
    // ------------------------------------------------------------------
    // Inputs only; outputs drop out of the comparison.
    assign mismatch = (pin_sync[7:4] ^ snapshot) & direction_reg[7:4]
                      & CHANGE_PINS_MASK;
    assign any_mismatch = |mismatch;

    // Snapshot refreshes on every port access.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            snapshot <= 4'h0;
        end else if (port_read) begin
            snapshot <= pin_sync[7:4];
        end
    end

    // After a port access the flag cannot be cleared for one instruction
    // cycle, so a late mismatch from the old snapshot is not lost.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            clr_block <= 2'h0;
        end else if (port_access) begin
            clr_block <= INSTR_CYCLE_CLKS;
        end else if (clr_block != 2'h0) begin
            clr_block <= clr_block - 2'h1;
        end
    end

    // Mismatch keeps setting the flag; set wins over a software clear.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            change_irq_flag <= 1'b0;
        end else if (any_mismatch) begin
            change_irq_flag <= 1'b1;
        end else if (wr_en && hit(paddr_i, ADDR_CTRL) && pstrb_i[0]
                     && !pwdata_i[CHANGE_FLAG_BIT] && clr_block == 2'h0) begin
            change_irq_flag <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Sticky interrupt status: change flag and rising external inputs.
    // ------------------------------------------------------------------
    assign ext_now = pin_sync[3:0] & direction_reg[3:0];
    assign events  = {ext_now & ~ext_prev, any_mismatch};

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ext_prev   <= 4'h0;
            irq_status <= '0;
        end else begin
            ext_prev <= ext_now;
            // Write one to clear; a new event in the same cycle wins.
            if (wr_en && hit(paddr_i, ADDR_IRQ_ST) && pstrb_i[0]) begin
                irq_status <= (irq_status & ~pwdata_i[IRQ_BITS-1:0]) | events;
            end else begin
                irq_status <= irq_status | events;
            end
        end
    end

    // ------------------------------------------------------------------
    // Pin drive: alternate outputs take priority over the latch.
    // ------------------------------------------------------------------
    always_comb begin
        next_pins = output_latch_reg;
        next_oe   = ~direction_reg;
        if (alt_sel[ALT_CMP2_BIT]) begin
            next_pins[2] = ctl_sync[1];
        end
        if (alt_sel[ALT_PWMB_BIT]) begin
            next_pins[1] = pwm_out_b_i;
        end
        if (alt_sel[ALT_PWMC_BIT] && !alt_sel[ALT_CMP2_BIT]) begin
            next_pins[2] = pwm_out_c_i;
        end
        if (alt_sel[ALT_PWMD_BIT]) begin
            next_pins[3] = pwm_out_d_i;
        end
        // Shutdown releases the PWM pins when tri-state is selected.
        if (alt_sel[ALT_TRI_BIT] && ctl_sync[2]) begin
            next_oe[1] = next_oe[1] & ~alt_sel[ALT_PWMB_BIT];
            next_oe[2] = next_oe[2] & ~alt_sel[ALT_PWMC_BIT];
            next_oe[3] = next_oe[3] & ~alt_sel[ALT_PWMD_BIT];
        end
        // Analog-selected pins never drive.
        next_oe[0] = next_oe[0] & ~alt_sel[ALT_ANA0_BIT];
        next_oe[1] = next_oe[1] & ~alt_sel[ALT_ANA1_BIT];
    end

    // ------------------------------------------------------------------
    // Registered pin and peripheral outputs.
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            port_b_pins_o          <= 8'h00;
            port_b_pins_oe_o       <= 8'h00;
            pullup_en_o            <= 8'h00;
            ext_irq_in_o           <= 4'h0;
            pwm_fault_in_o         <= 1'b0;
            analog_ch_ten_en_o     <= 1'b1;
            analog_ch_eight_en_o   <= 1'b1;
            timing_unit_delay_in_o <= 1'b0;
            timing_edge_one_in_o   <= 1'b0;
            timing_edge_two_in_o   <= 1'b0;
            timer_clk_in_o         <= 1'b0;
            timer_gate_in_o        <= 1'b0;
            wake_o                 <= 1'b0;
            irq_o                  <= 1'b0;
        end else begin
            port_b_pins_o    <= next_pins;
            port_b_pins_oe_o <= next_oe;
            // Global enable is active low; outputs are always excluded.
            pullup_en_o <= {8{~irq_control_two[PULLUP_DIS_BIT]}}
                           & direction_reg;
            // External interrupt inputs of analog pins read low until reconfigured.
            ext_irq_in_o <= pin_sync[3:0] & direction_reg[3:0]
                            & ~{2'b00, alt_sel[ALT_ANA1_BIT],
                                alt_sel[ALT_ANA0_BIT]};
            pwm_fault_in_o       <= pin_sync[0];
            analog_ch_ten_en_o   <= alt_sel[ALT_ANA0_BIT];
            analog_ch_eight_en_o <= alt_sel[ALT_ANA1_BIT];
            timing_unit_delay_in_o <= pin_sync[1] & direction_reg[1];
            timing_edge_one_in_o <= pin_sync[2];
            timing_edge_two_in_o <= pin_sync[3];
            timer_clk_in_o  <= pin_sync[PIN_T5] & ~alt_sel[ALT_T5GATE_BIT];
            timer_gate_in_o <= pin_sync[PIN_T5] & alt_sel[ALT_T5GATE_BIT];
            // Wake needs change_ie but not irq_mask, so sleep can end while irq_o is masked.
            wake_o <= change_irq_flag & change_ie;
            irq_o  <= |(irq_status & irq_mask);
        end
    end

    // ------------------------------------------------------------------
    // APB read data and zero-wait answer.
    // ------------------------------------------------------------------
    always_comb begin
        next_rdata = 32'h0000_0000;
        unique case (paddr_i)
            ADDR_PORT:    next_rdata[7:0] = pin_sync;
            ADDR_LATCH:   next_rdata[7:0] = output_latch_reg;
            ADDR_DIR:     next_rdata[7:0] = direction_reg;
            ADDR_CTRL2:   next_rdata[7:0] = irq_control_two;
            ADDR_CTRL:    next_rdata[1:0] = {change_ie, change_irq_flag};
            ADDR_ALT:     next_rdata[7:0] = alt_sel;
            ADDR_IRQ_ST:  next_rdata[IRQ_BITS-1:0] = irq_status;
            ADDR_IRQ_MSK: next_rdata[IRQ_BITS-1:0] = irq_mask;
            default:      next_rdata = 32'h0000_0000;
        endcase
    end

    // Answer in the setup cycle so pready is high in the access phase.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            prdata_o  <= 32'h0000_0000;
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end else begin
            pready_o  <= psel_i & ~penable_i;
            prdata_o  <= (psel_i & ~penable_i & ~pwrite_i) ? next_rdata : 32'h0000_0000;
            pslverr_o <= psel_i & ~penable_i & (paddr_i > ADDR_IRQ_MSK
                         || paddr_i[1:0] != 2'b00);
        end
    end

endmodule

`default_nettype wire

// ---- gpb_pkg.sv ----
// Constants, register map and field positions for the byte-wide port block.
// Assumes an APB slave with 32-bit data; registers sit on aligned words.
`default_nettype none

package gpb_pkg;

    // ------------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------------
    localparam logic [11:0] ADDR_PORT    = 12'h000;
    localparam logic [11:0] ADDR_LATCH   = 12'h004;
    localparam logic [11:0] ADDR_DIR     = 12'h008;
    localparam logic [11:0] ADDR_CTRL2   = 12'h00c;
    localparam logic [11:0] ADDR_CTRL    = 12'h010;
    localparam logic [11:0] ADDR_ALT     = 12'h014;
    localparam logic [11:0] ADDR_IRQ_ST  = 12'h018;
    localparam logic [11:0] ADDR_IRQ_MSK = 12'h01c;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int PULLUP_DIS_BIT = 7;
    localparam int CHANGE_FLAG_BIT = 0;
    localparam int ALT_ANA0_BIT   = 0;
    localparam int ALT_ANA1_BIT   = 1;
    localparam int ALT_CMP2_BIT   = 2;
    localparam int ALT_PWMB_BIT   = 3;
    localparam int ALT_PWMC_BIT   = 4;
    localparam int ALT_PWMD_BIT   = 5;
    localparam int ALT_TRI_BIT    = 6;
    localparam int ALT_T5GATE_BIT = 7;
    localparam int PIN_T5         = 5;
    localparam int IRQ_CHANGE     = 0;
    localparam int IRQ_EXT_LO     = 1;
    localparam int IRQ_BITS       = 5;
    localparam logic [7:0] DIR_RESET  = 8'hff;
    localparam logic [7:0] LAT_RESET  = 8'h00;
    localparam logic [7:0] CTRL2_RESET = 8'h80;
    localparam logic [7:0] ALT_RESET  = 8'h03;
    localparam logic [3:0] CHANGE_PINS_MASK = 4'hf;
    // Number of clocks that one instruction cycle spans.
    localparam logic [1:0] INSTR_CYCLE_CLKS = 2'h1;

endpackage

`default_nettype wire

// ---- gpb_port_asserts.sv ----
// Concurrent checks on the ports of the byte-wide port block.
// Assumes it is bound into gpb_port and sees only that module's ports.
`default_nettype none

module gpb_port_asserts (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic [7:0]  port_b_pins_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic [7:0]  port_b_pins_oe_o,
    input wire logic [7:0]  pullup_en_o,
    input wire logic [3:0]  ext_irq_in_o,
    input wire logic        analog_ch_ten_en_o,
    input wire logic        analog_ch_eight_en_o,
    input wire logic        timing_edge_one_in_o,
    input wire logic        timing_edge_two_in_o,
    input wire logic        timer_clk_in_o,
    input wire logic        timer_gate_in_o,
    input wire logic        wake_o,
    input wire logic        irq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] up_cnt;

    // Cycles since reset; synchroniser history is only valid after three.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            up_cnt <= 3'h0;
        end else if (up_cnt != 3'h7) begin
            up_cnt <= up_cnt + 3'h1;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // ------------------------------------------------------------------
    // Port assertions
    // ------------------------------------------------------------------
    chk_pullup_out_off: assert property (!(|(pullup_en_o & port_b_pins_oe_o)))
        else $error("pull-up enabled on a driven pin");
    chk_pullup_reset: assert property (disable iff (1'b0) rst_i |-> pullup_en_o == 8'h00)
        else $error("pull-up enabled during reset");
    chk_analog_reset: assert property (disable iff (1'b0) rst_i |-> analog_ch_ten_en_o && analog_ch_eight_en_o)
        else $error("analog defaults missing in reset");
    chk_ready_time: assert property (psel_i && !penable_i |=> pready_o)
        else $error("ready not in access phase");
    chk_ready_pulse: assert property (pready_o |=> !pready_o)
        else $error("ready longer than one cycle");
    chk_err_with_ready: assert property (pslverr_o |-> pready_o)
        else $error("error without ready");
    chk_rdata_idle: assert property (!pready_o |-> prdata_o == 32'h0)
        else $error("read data outside access");
    chk_ext_in_only: assert property (($past(port_b_pins_oe_o, 2) == port_b_pins_oe_o
        && $past(port_b_pins_oe_o) == port_b_pins_oe_o)
        |-> (ext_irq_in_o & port_b_pins_oe_o[3:0]) == 4'h0)
        else $error("external interrupt from output pin");
    chk_edge_follow: assert property (up_cnt > 3'h3 |->
        timing_edge_one_in_o == $past(port_b_pins_i[2], 3)
        && timing_edge_two_in_o == $past(port_b_pins_i[3], 3))
        else $error("timing edge inputs do not follow pins");
    chk_timer_sel: assert property (!(timer_clk_in_o && timer_gate_in_o))
        else $error("pin five routed to both timers");

    cover property (wake_o);
    cover property (irq_o);
    cover property (pslverr_o);
endmodule

`default_nettype wire

// ---- gpb_pin_model.sv ----
// Board-side model of the eight pins: design drive, external drive, pull-up.
// Where the bench and the design both drive a pin, the design drive wins.
`default_nettype none

module gpb_pin_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] drv_i,
    input  wire logic [7:0] oe_i,
    input  wire logic [7:0] pullup_i,
    input  wire logic [7:0] ext_val_i,
    input  wire logic [7:0] ext_en_i,
    output logic      [7:0] level_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic flip = 1'b0;

    // A floating pin wanders, so a stale value can never pass for data.
    always_ff @(posedge clk_i) begin
        flip <= ~flip;
    end

    // Each pin is digital: driver first, then outside drive, then pull-up.
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            level_o[i] = oe_i[i] ? drv_i[i] :
                         ext_en_i[i] ? ext_val_i[i] :
                         pullup_i[i] ? 1'b1 : flip;
        end
    end
endmodule

`default_nettype wire

// ---- byte_wide_port_with_change_irq_tb.sv ----
// Self-checking bench for the byte-wide port block.
// Assumes gpb_port, its package, the pin model and the checker are compiled.
`default_nettype none

module byte_wide_port_with_change_irq_tb;
    import gpb_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i = 1'b0;
    logic        rst_i, psel_i, penable_i, pwrite_i, last_err;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o, r, d, seed;
    logic [3:0]  pstrb_i, ext_irq_in_o;
    logic        pready_o, pslverr_o, comparator_one_out_i, pwm_out_b_i, pwm_out_c_i;
    logic        pwm_out_d_i, pwm_shutdown_i, pwm_fault_in_o, analog_ch_ten_en_o;
    logic        analog_ch_eight_en_o, timing_unit_delay_in_o, timing_edge_one_in_o;
    logic        timing_edge_two_in_o, timer_clk_in_o, timer_gate_in_o, wake_o, irq_o;
    logic [7:0]  port_b_pins_i, port_b_pins_o, port_b_pins_oe_o, pullup_en_o;
    logic [7:0]  ext_val, ext_en;
    int          fail_count = 0;
    int          n_compared = 0;
    int          cyc = 0;
    logic [11:0] rst_addr [4] = '{ADDR_DIR, ADDR_LATCH, ADDR_CTRL2, ADDR_ALT};
    logic [7:0]  rst_val  [4] = '{DIR_RESET, LAT_RESET, CTRL2_RESET, ALT_RESET};

    gpb_port u_gpb_port (.*);
    gpb_pin_model u_gpb_pin_model (.clk_i(clk_i), .drv_i(port_b_pins_o),
        .oe_i(port_b_pins_oe_o), .pullup_i(pullup_en_o), .ext_val_i(ext_val),
        .ext_en_i(ext_en), .level_o(port_b_pins_i));

    // Free-running clock at 125 MHz.
    always #4 clk_i = ~clk_i;

    // A hang ends in the verdict as one more mismatch.
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fail_count++;
            tally_and_finish();
        end
    end

    // ------------------------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Request held until ready is seen at a rising edge, then released.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= wd;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do @(posedge clk_i); while (pready_o !== 1'b1);
        r = prdata_o;
        last_err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(r, exp);
    endtask

    task automatic tally_and_finish();
        if (fail_count == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        {rst_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = {1'b1, 47'h0};
        {comparator_one_out_i, pwm_out_b_i, pwm_out_c_i, pwm_out_d_i} = 4'h0;
        pwm_shutdown_i = 1'b0;
        pstrb_i = 4'hf;
        ext_val = 8'h00;
        ext_en = 8'hff;
        seed = 32'h469596e1;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        chk({analog_ch_ten_en_o, analog_ch_eight_en_o, pullup_en_o}, 32'h300);
        for (int i = 0; i < 4; i++) rd(rst_addr[i], {24'h0, rst_val[i]});
        rd(12'h020, 32'h0);
        chk(last_err, 1'b1);
        // Random pin levels read back and routed to the peripheral inputs.
        apb(1'b1, ADDR_ALT, 32'h0);
        for (int k = 0; k < 6; k++) begin
            ext_val <= $random(seed);
            repeat (5) @(posedge clk_i);
            rd(ADDR_PORT, {24'h0, ext_val});
            chk({pwm_fault_in_o, ext_irq_in_o}, {ext_val[0], ext_val[3:0]});
            chk(timing_unit_delay_in_o, ext_val[1]);
        end
        // Pull-ups on inputs only, latch on the output pins.
        d = $random(seed);
        ext_en <= 8'h00;
        apb(1'b1, ADDR_DIR, 32'hcf);
        apb(1'b1, ADDR_LATCH, d);
        apb(1'b1, ADDR_CTRL2, 32'h0);
        repeat (5) @(posedge clk_i);
        chk({port_b_pins_oe_o, pullup_en_o}, 16'h30cf);
        rd(ADDR_PORT, {24'h0, 2'b11, d[5:4], 4'hf});
        apb(1'b1, ADDR_CTRL2, 32'h80);
        repeat (2) @(posedge clk_i);
        chk(pullup_en_o, 8'h00);
        // Change detection on inputs 7:4, output pin 7 and low pins excluded.
        ext_en <= 8'h7f;
        ext_val <= 8'h00;
        apb(1'b1, ADDR_DIR, 32'h7f);
        apb(1'b1, ADDR_IRQ_MSK, 32'h1);
        apb(1'b1, ADDR_CTRL, 32'h2);
        repeat (5) @(posedge clk_i);
        // One deliberate read arms the snapshot; no polling follows.
        apb(1'b0, ADDR_PORT, 32'h0);
        apb(1'b1, ADDR_IRQ_ST, 32'h1f);
        apb(1'b1, ADDR_LATCH, 32'h80);
        ext_val <= 8'h04;
        repeat (6) @(posedge clk_i);
        chk(irq_o, 1'b0);
        ext_val <= 8'h44;
        repeat (6) @(posedge clk_i);
        chk({irq_o, wake_o}, 2'b11);
        apb(1'b1, ADDR_CTRL, 32'h2);
        rd(ADDR_CTRL, 32'h3);
        apb(1'b1, ADDR_IRQ_MSK, 32'h0);
        repeat (2) @(posedge clk_i);
        chk(irq_o, 1'b0);
        apb(1'b1, ADDR_IRQ_MSK, 32'h1);
        rd(ADDR_PORT, 32'hc4);
        apb(1'b1, ADDR_CTRL, 32'h2);
        rd(ADDR_CTRL, 32'h2);
        apb(1'b1, ADDR_IRQ_ST, 32'h1);
        repeat (2) @(posedge clk_i);
        chk({irq_o, wake_o}, 2'b00);
        // Comparator and pulse-width outputs over the latch, shutdown tri-state.
        ext_en <= 8'h00;
        {comparator_one_out_i, pwm_out_b_i, pwm_shutdown_i} <= 3'b111;
        apb(1'b1, ADDR_LATCH, 32'h01);
        apb(1'b1, ADDR_DIR, 32'h0);
        apb(1'b1, ADDR_ALT, 32'h4c);
        repeat (6) @(posedge clk_i);
        chk({port_b_pins_o[2], port_b_pins_oe_o[1], pwm_fault_in_o}, 3'b101);
        pwm_shutdown_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        chk({port_b_pins_oe_o[1], port_b_pins_o[1]}, 2'b11);
        // Pin five steered to the timer gate, then back to the clock.
        ext_en <= 8'hff;
        ext_val <= 8'h20;
        apb(1'b1, ADDR_DIR, 32'hff);
        apb(1'b1, ADDR_ALT, 32'h80);
        repeat (6) @(posedge clk_i);
        chk({timer_gate_in_o, timer_clk_in_o}, 2'b10);
        apb(1'b1, ADDR_ALT, 32'h0);
        repeat (3) @(posedge clk_i);
        chk({timer_gate_in_o, timer_clk_in_o}, 2'b01);
        tally_and_finish();
    end
endmodule

bind gpb_port gpb_port_asserts u_gpb_port_asserts (.*);

`default_nettype wire
